/* logic/hum_cfg.svh */
// Purpose: timing counts, addresses and command codes
// Assumes: 25 MHz system clock
// Notes:   settle and measurement times are worst-case figures
`ifndef HUM_CFG_SVH
`define HUM_CFG_SVH
`define HUM_CLK_HZ         25000000
`define HUM_US2CYC(t)      ((t) * (`HUM_CLK_HZ / 1000000))
`define HUM_PU_TIME_US     1000
`define HUM_SR_TIME_US     1000
`define HUM_MEAS_L_US      4000
`define HUM_MEAS_M_US      6000
`define HUM_MEAS_H_US      15000
`define HUM_RST_PULSE_NS   350
`define HUM_RST_PULSE_CYC  ((`HUM_RST_PULSE_NS * 25 + 999) / 1000)
`define HUM_ADDR_LO        7'h44
`define HUM_ADDR_HI        7'h45
`define HUM_CMD_STR        8'h2c
`define HUM_CMD_NOSTR      8'h24
`define HUM_LSB_STR_H      8'h06
`define HUM_LSB_STR_M      8'h0d
`define HUM_LSB_STR_L      8'h10
`define HUM_LSB_NOSTR_H    8'h00
`define HUM_LSB_NOSTR_M    8'h0b
`define HUM_LSB_NOSTR_L    8'h16
`define HUM_CMD_SRST       16'h3001
`define HUM_SCL_QTR        4'h9
`define HUM_RD_BYTES       3'h5
`define HUM_WR_BYTES       3'h3
`endif

/* logic/hum_pkg.sv */
// Purpose: shared types of both bus ends
// Assumes: nothing
// Notes:   binary state codes
package hum_pkg;
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0, DS_RX = 3'h1, DS_ACKR = 3'h2, DS_TX = 3'h3,
    DS_ACKT = 3'h4, DS_STR = 3'h5, DS_WAIT = 3'h6
  } hum_dstate_e;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0, HS_RST = 3'h1, HS_START = 3'h2, HS_BIT = 3'h3,
    HS_STOP = 3'h4
  } hum_hstate_e;
endpackage

/* logic/hum_bus_if.sv */
// Purpose: two-wire bus plus side pins between master and sensor
// Assumes: external pull-ups on both lines
// Notes:   a line is low when any party enables a low drive
`timescale 1ns/1ps
interface hum_bus_if;
  logic scl_dev_o;
  logic scl_dev_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic scl;
  logic sda;
  logic addr_sel;
  logic hard_reset_n;
  logic alert;
  // -------------------------------------------------------------
  // wired-and resolution
  // -------------------------------------------------------------
  assign scl = (scl_dev_oe ? scl_dev_o : 1'b1) &
               (scl_host_oe ? scl_host_o : 1'b1);
  assign sda = (sda_dev_oe ? sda_dev_o : 1'b1) &
               (sda_host_oe ? sda_host_o : 1'b1);
  modport dev (input scl, sda, addr_sel, hard_reset_n,
               output scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe, alert);
  modport host (input scl, sda, alert,
                output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe,
                addr_sel, hard_reset_n);
endinterface

/* logic/hum_dev.sv */
// Purpose: sensor end: bus slave, settle timers, measurement, alarm
// Assumes: nrst is the power-on reset; readings come from user ports
// Notes:   readout is temperature then humidity, no checksum
// Overview of operation
// - power-up reaches idle within one time unit
// - soft reset reaches idle within one unit
// - low hard reset input resets the sensor
// - master holds hard reset low 350 ns
// - measurement ends within 4, 6, 15 ms
// - bus clock from zero to 1000 kHz
// - stretch clock low on stretching commands
// - lines only pulled low, never driven high
// - address 0x44 select low, 0x45 high
// - select pin followed between transactions
// - master keeps select stable during transaction
// - upper seven header bits address, bit0 direction
// - alarm high when reading meets limits
// - commands accepted only once idle entered
// - headers refused while measuring, except stretch read
`timescale 1ns/1ps
`include "hum_cfg.svh"
module hum_dev import hum_pkg::*; #(
  parameter int unsigned PU_CYC = `HUM_US2CYC(`HUM_PU_TIME_US),
  parameter int unsigned SR_CYC = `HUM_US2CYC(`HUM_SR_TIME_US),
  parameter int unsigned MEAS_L_CYC = `HUM_US2CYC(`HUM_MEAS_L_US),
  parameter int unsigned MEAS_M_CYC = `HUM_US2CYC(`HUM_MEAS_M_US),
  parameter int unsigned MEAS_H_CYC = `HUM_US2CYC(`HUM_MEAS_H_US)
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  hum_bus_if.dev           bus,
  input  wire logic [15:0] temp_val,
  input  wire logic [15:0] hum_val,
  input  wire logic [15:0] temp_lim,
  input  wire logic [15:0] hum_lim,
  output logic             ready,
  output logic             busy
);
  // -------------------------------------------------------------
  // pin synchronisers and edge detection
  // -------------------------------------------------------------
  logic [1:0]  scl_s_ff, sda_s_ff, adr_s_ff, hrs_s_ff;
  logic        scl_d_ff, sda_d_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_s_ff <= 2'h3;
      sda_s_ff <= 2'h3;
      adr_s_ff <= 2'h0;
      hrs_s_ff <= 2'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_s_ff <= {scl_s_ff[0], bus.scl};
      sda_s_ff <= {sda_s_ff[0], bus.sda};
      adr_s_ff <= {adr_s_ff[0], bus.addr_sel};
      hrs_s_ff <= {hrs_s_ff[0], bus.hard_reset_n};
      scl_d_ff <= scl_s_ff[1];
      sda_d_ff <= sda_s_ff[1];
    end
  end
  logic scl_h, sda_h, scl_rise, scl_fall, bus_start, bus_stop, hrst;
  assign scl_h     = scl_s_ff[1];
  assign sda_h     = sda_s_ff[1];
  assign scl_rise  = scl_h & ~scl_d_ff;
  assign scl_fall  = ~scl_h & scl_d_ff;
  assign bus_start = scl_h & scl_d_ff & sda_d_ff & ~sda_h;
  assign bus_stop  = scl_h & scl_d_ff & ~sda_d_ff & sda_h;
  assign hrst      = ~hrs_s_ff[1];
  // -------------------------------------------------------------
  // slave state and decode
  // -------------------------------------------------------------
  hum_dstate_e state_ff, after_ff;
  logic [3:0]  bcnt_ff;
  logic [1:0]  bidx_ff, tidx_ff;
  logic [7:0]  sh_ff, cmdh_ff, tx_ff;
  logic [6:0]  my_addr_ff;
  logic        sda_oe_ff, scl_oe_ff, ready_ff, meas_ff, valid_ff;
  logic        str_ff, alert_ff;
  logic [19:0] settle_ff, mcnt_ff;
  logic [31:0] res_ff;
  logic        ack_fall, ack_now, is_meas, go_str, meas_go, srst_go;
  logic [15:0] cmd;
  logic [19:0] meas_len;
  assign ack_fall = (state_ff == DS_RX) && scl_fall && (bcnt_ff == 4'h8);
  assign cmd = {cmdh_ff, sh_ff};
  always_comb begin
    is_meas  = 1'b1;
    go_str   = 1'b0;
    meas_len = 20'(MEAS_H_CYC);
    case (cmd)
      {`HUM_CMD_STR, `HUM_LSB_STR_H}: go_str = 1'b1;
      {`HUM_CMD_STR, `HUM_LSB_STR_M}: begin
        go_str   = 1'b1;
        meas_len = 20'(MEAS_M_CYC);
      end
      {`HUM_CMD_STR, `HUM_LSB_STR_L}: begin
        go_str   = 1'b1;
        meas_len = 20'(MEAS_L_CYC);
      end
      {`HUM_CMD_NOSTR, `HUM_LSB_NOSTR_H}: go_str = 1'b0;
      {`HUM_CMD_NOSTR, `HUM_LSB_NOSTR_M}: meas_len = 20'(MEAS_M_CYC);
      {`HUM_CMD_NOSTR, `HUM_LSB_NOSTR_L}: meas_len = 20'(MEAS_L_CYC);
      default: is_meas = 1'b0;
    endcase
  end
  always_comb begin
    if (bidx_ff == 2'h0) begin
      // header: address match, direction in bit 0
      ack_now = (sh_ff[7:1] == my_addr_ff) && ready_ff &&
                (sh_ff[0] ? ((meas_ff & str_ff) | (valid_ff & ~meas_ff))
                          : ~meas_ff);
    end else begin
      ack_now = ready_ff;
    end
  end
  assign meas_go = ack_fall && ack_now && (bidx_ff == 2'h2) && is_meas;
  assign srst_go = ack_fall && ack_now && (bidx_ff == 2'h2) &&
                   (cmd == `HUM_CMD_SRST);
  // -------------------------------------------------------------
  // settle timer: power-up, hard reset, soft reset
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settle_ff <= 20'(PU_CYC - 1);
      ready_ff  <= 1'b0;
    end else if (hrst) begin
      settle_ff <= 20'(PU_CYC - 1);
      ready_ff  <= 1'b0;
    end else if (srst_go) begin
      settle_ff <= 20'(SR_CYC - 1);
      ready_ff  <= 1'b0;
    end else if (!ready_ff) begin
      if (settle_ff == 20'h0) begin
        ready_ff <= 1'b1;
      end else begin
        settle_ff <= settle_ff - 20'h1;
      end
    end
  end
  // -------------------------------------------------------------
  // measurement timer and result
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meas_ff  <= 1'b0;
      valid_ff <= 1'b0;
      str_ff   <= 1'b0;
      mcnt_ff  <= 20'h0;
      res_ff   <= 32'h0;
    end else if (hrst || srst_go) begin
      meas_ff  <= 1'b0;
      valid_ff <= 1'b0;
    end else if (meas_go) begin
      meas_ff  <= 1'b1;
      valid_ff <= 1'b0;
      str_ff   <= go_str;
      mcnt_ff  <= meas_len - 20'h1;
    end else if (meas_ff) begin
      if (mcnt_ff == 20'h0) begin
        meas_ff  <= 1'b0;
        valid_ff <= 1'b1;
        res_ff   <= {temp_val, hum_val};
      end else begin
        mcnt_ff <= mcnt_ff - 20'h1;
      end
    end
  end
  // -------------------------------------------------------------
  // alarm output
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alert_ff <= 1'b0;
    end else begin
      alert_ff <= valid_ff && ((res_ff[31:16] >= temp_lim) ||
                               (res_ff[15:0] >= hum_lim));
    end
  end
  // -------------------------------------------------------------
  // bus slave
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff   <= DS_IDLE;
      after_ff   <= DS_IDLE;
      bcnt_ff    <= 4'h0;
      bidx_ff    <= 2'h0;
      tidx_ff    <= 2'h0;
      sh_ff      <= 8'h0;
      cmdh_ff    <= 8'h0;
      tx_ff      <= 8'h0;
      my_addr_ff <= `HUM_ADDR_LO;
      sda_oe_ff  <= 1'b0;
      scl_oe_ff  <= 1'b0;
    end else if (hrst || bus_stop) begin
      state_ff  <= DS_IDLE;
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
    end else if (bus_start) begin
      state_ff   <= DS_RX;
      bcnt_ff    <= 4'h0;
      bidx_ff    <= 2'h0;
      sda_oe_ff  <= 1'b0;
      my_addr_ff <= adr_s_ff[1] ? `HUM_ADDR_HI
                                : `HUM_ADDR_LO;
    end else begin
      case (state_ff)
        DS_RX: begin
          if (scl_rise) begin
            sh_ff   <= {sh_ff[6:0], sda_h};
            bcnt_ff <= bcnt_ff + 4'h1;
          end else if (ack_fall) begin
            bcnt_ff <= 4'h0;
            bidx_ff <= bidx_ff + {1'b0, (bidx_ff != 2'h3)};
            if (bidx_ff == 2'h1) begin
              cmdh_ff <= sh_ff;
            end
            if (ack_now) begin
              sda_oe_ff <= 1'b1;
              state_ff  <= DS_ACKR;
              if (bidx_ff != 2'h0 || !sh_ff[0]) begin
                after_ff <= DS_RX;
              end else if (meas_ff) begin
                after_ff <= DS_STR;
              end else begin
                after_ff <= DS_TX;
              end
            end else begin
              state_ff <= DS_WAIT;
            end
          end
        end
        DS_ACKR: begin
          if (scl_fall) begin
            state_ff <= after_ff;
            tidx_ff  <= 2'h0;
            if (after_ff == DS_TX) begin
              tx_ff     <= res_ff[31:24];
              sda_oe_ff <= ~res_ff[31];
            end else begin
              sda_oe_ff <= 1'b0;
            end
            scl_oe_ff <= (after_ff == DS_STR);
          end
        end
        DS_STR: begin
          if (valid_ff) begin
            if (bcnt_ff == 4'h0) begin
              tx_ff     <= res_ff[31:24];
              sda_oe_ff <= ~res_ff[31];
              bcnt_ff   <= 4'h1;
            end else begin
              scl_oe_ff <= 1'b0;
              bcnt_ff   <= 4'h0;
              state_ff  <= DS_TX;
            end
          end
        end
        DS_TX: begin
          if (scl_rise) begin
            bcnt_ff <= bcnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bcnt_ff == 4'h8) begin
              sda_oe_ff <= 1'b0;
              state_ff  <= DS_ACKT;
            end else begin
              sda_oe_ff <= ~tx_ff[6];
              tx_ff     <= {tx_ff[6:0], 1'b0};
            end
          end
        end
        DS_ACKT: begin
          if (scl_rise && (sda_h || tidx_ff == 2'h3)) begin
            state_ff <= DS_WAIT;
          end else if (scl_fall) begin
            bcnt_ff   <= 4'h0;
            tidx_ff   <= tidx_ff + 2'h1;
            tx_ff     <= res_ff[8 * (2 - tidx_ff) +: 8];
            sda_oe_ff <= ~res_ff[8 * (2 - tidx_ff) + 7];
            state_ff  <= DS_TX;
          end
        end
        default: state_ff <= state_ff;
      endcase
    end
  end
  assign bus.scl_dev_o  = 1'b0;
  assign bus.sda_dev_o  = 1'b0;
  assign bus.scl_dev_oe = scl_oe_ff;
  assign bus.sda_dev_oe = sda_oe_ff;
  assign bus.alert      = alert_ff;
  assign ready          = ready_ff;
  assign busy           = meas_ff;
endmodule

/* logic/hum_host.sv */
// Purpose: bus master end: writes commands, reads results, resets
// Assumes: master makes the bus clock by dividing clk
// Notes:   one request at a time
`timescale 1ns/1ps
`include "hum_cfg.svh"
module hum_host import hum_pkg::*; (
  input  wire logic        clk,
  input  wire logic        nrst,
  hum_bus_if.host          bus,
  input  wire logic        req_valid,
  input  wire logic        req_read,
  input  wire logic [15:0] req_cmd,
  input  wire logic        req_addr_sel,
  input  wire logic        req_hard_rst,
  output logic             busy,
  output logic             done,
  output logic             nack_err,
  output logic [31:0]      rd_data
);
  // -------------------------------------------------------------
  // line synchronisers
  // -------------------------------------------------------------
  logic [1:0] scl_s_ff, sda_s_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_s_ff <= 2'h3;
      sda_s_ff <= 2'h3;
    end else begin
      scl_s_ff <= {scl_s_ff[0], bus.scl};
      sda_s_ff <= {sda_s_ff[0], bus.sda};
    end
  end
  // -------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------
  hum_hstate_e state_ff;
  logic [3:0]  q_ff, bit_ff;
  logic [1:0]  ph_ff;
  logic [2:0]  byte_ff;
  logic        rd_ff, adr_ff, rstn_ff, scl_oe_ff, sda_oe_ff;
  logic        done_ff, err_ff;
  logic [15:0] cmd_ff;
  logic [31:0] data_ff;
  logic [7:0]  cur;
  logic        tick, stall, wr_byte, last;
  assign stall = (ph_ff == 2'h2) && !scl_s_ff[1];
  assign tick  = (q_ff == `HUM_SCL_QTR) && !stall;
  assign wr_byte = (byte_ff == 3'h0) || !rd_ff;
  assign last  = byte_ff == (rd_ff ? `HUM_RD_BYTES : `HUM_WR_BYTES) - 3'h1;
  always_comb begin
    case (byte_ff)
      3'h0:    cur = {adr_ff ? `HUM_ADDR_HI : `HUM_ADDR_LO, rd_ff};
      3'h1:    cur = cmd_ff[15:8];
      default: cur = cmd_ff[7:0];
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff  <= HS_IDLE;
      q_ff      <= 4'h0;
      ph_ff     <= 2'h0;
      bit_ff    <= 4'h0;
      byte_ff   <= 3'h0;
      rd_ff     <= 1'b0;
      adr_ff    <= 1'b0;
      rstn_ff   <= 1'b1;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      done_ff   <= 1'b0;
      err_ff    <= 1'b0;
      cmd_ff    <= 16'h0;
      data_ff   <= 32'h0;
    end else begin
      done_ff <= 1'b0;
      q_ff    <= (tick || state_ff == HS_IDLE) ? 4'h0
                 : q_ff + {3'h0, (q_ff != `HUM_SCL_QTR)};
      if (tick && state_ff != HS_RST) begin
        ph_ff <= ph_ff + 2'h1;
      end
      case (state_ff)
        HS_IDLE: begin
          ph_ff <= 2'h0;
          if (req_hard_rst) begin
            rstn_ff  <= 1'b0;
            q_ff     <= 4'(`HUM_RST_PULSE_CYC - 1);
            state_ff <= HS_RST;
          end else if (req_valid) begin
            rd_ff    <= req_read;
            cmd_ff   <= req_cmd;
            adr_ff   <= req_addr_sel;
            err_ff   <= 1'b0;
            byte_ff  <= 3'h0;
            state_ff <= HS_START;
          end
        end
        HS_RST: begin
          if (q_ff == 4'h0) begin
            rstn_ff  <= 1'b1;
            done_ff  <= 1'b1;
            state_ff <= HS_IDLE;
          end else begin
            q_ff <= q_ff - 4'h1;
          end
        end
        HS_START: begin
          if (tick && ph_ff == 2'h1) begin
            sda_oe_ff <= 1'b1;
          end else if (tick && ph_ff == 2'h2) begin
            scl_oe_ff <= 1'b1;
          end else if (tick && ph_ff == 2'h3) begin
            bit_ff   <= 4'h0;
            state_ff <= HS_BIT;
          end
        end
        HS_BIT: begin
          if (tick && ph_ff == 2'h0) begin
            if (bit_ff != 4'h8) begin
              sda_oe_ff <= wr_byte && !cur[3'(7 - bit_ff)];
            end else begin
              sda_oe_ff <= !wr_byte && !last;
            end
          end else if (tick && ph_ff == 2'h1) begin
            scl_oe_ff <= 1'b0;
          end else if (tick && ph_ff == 2'h3) begin
            scl_oe_ff <= 1'b1;
            bit_ff    <= bit_ff + 4'h1;
            if (bit_ff != 4'h8) begin
              if (!wr_byte) begin
                data_ff <= {data_ff[30:0], scl_s_ff[1] & sda_s_ff[1]};
              end
            end else begin
              bit_ff  <= 4'h0;
              byte_ff <= byte_ff + 3'h1;
              if (wr_byte && sda_s_ff[1]) begin
                err_ff   <= 1'b1;
                state_ff <= HS_STOP;
              end else if (last) begin
                state_ff <= HS_STOP;
              end
            end
          end
        end
        HS_STOP: begin
          if (tick && ph_ff == 2'h0) begin
            sda_oe_ff <= 1'b1;
          end else if (tick && ph_ff == 2'h1) begin
            scl_oe_ff <= 1'b0;
          end else if (tick && ph_ff == 2'h2) begin
            sda_oe_ff <= 1'b0;
          end else if (tick && ph_ff == 2'h3) begin
            done_ff  <= 1'b1;
            state_ff <= HS_IDLE;
          end
        end
        default: state_ff <= HS_IDLE;
      endcase
    end
  end
  assign bus.scl_host_o   = 1'b0;
  assign bus.sda_host_o   = 1'b0;
  assign bus.scl_host_oe  = scl_oe_ff;
  assign bus.sda_host_oe  = sda_oe_ff;
  assign bus.addr_sel     = adr_ff;
  assign bus.hard_reset_n = rstn_ff;
  assign busy     = (state_ff != HS_IDLE);
  assign done     = done_ff;
  assign nack_err = err_ff;
  assign rd_data  = data_ff;
endmodule

/* verif/hum_chk.sv */
// Purpose: bus checks between master and sensor ends
// Assumes: one clock domain, nrst async active low
// Notes:   sees interface signals only
`timescale 1ns/1ps
module hum_chk #(
  parameter int unsigned MEAS_H_CYC = 375000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic scl_dev_o,
  input wire logic scl_dev_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic scl_host_o,
  input wire logic scl_host_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic addr_sel,
  input wire logic hard_reset_n,
  input wire logic alert
);
  // ----------------------------------------
  // clock hold length
  // ----------------------------------------
  logic [31:0] hold_cnt_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt_ff <= '0;
    end else begin
      hold_cnt_ff <= scl_dev_oe ? hold_cnt_ff + 32'h1 : '0;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence rst_hold_s;
    !hard_reset_n [*8];
  endsequence
  sequence rst_seen_s;
    !hard_reset_n [*4];
  endsequence
  dev_scl_low_a: assert property (scl_dev_oe |-> !scl_dev_o)
    else $error("sensor drives clock high");
  dev_sda_low_a: assert property (sda_dev_oe |-> !sda_dev_o)
    else $error("sensor drives data high");
  host_scl_low_a: assert property (scl_host_oe |-> !scl_host_o)
    else $error("master drives clock high");
  host_sda_low_a: assert property (sda_host_oe |-> !sda_host_o)
    else $error("master drives data high");
  rst_pulse_len_a: assert property (
    $fell(hard_reset_n) |=> rst_hold_s)
    else $error("hard reset pulse too short");
  rst_clears_a: assert property (rst_seen_s |=>
    !sda_dev_oe && !scl_dev_oe && !alert)
    else $error("sensor not cleared by hard reset");
  stretch_bound_a: assert property (hold_cnt_ff <= MEAS_H_CYC)
    else $error("clock held low too long");
  stretch_start_a: assert property (
    $rose(scl_dev_oe) |-> !$past(scl))
    else $error("stretch began with clock high");
  dev_sda_stable_a: assert property (scl && $past(scl) |->
    $stable(sda_dev_oe))
    else $error("sensor data moved while clock high");
  addr_stable_a: assert property (!scl |-> $stable(addr_sel))
    else $error("select pin moved in transaction");
endmodule

/* verif/humidity_sensor_bus_timing_reset_tb.sv */
// Purpose: both bus ends joined, results noted and compared
// Assumes: 25 MHz clock, short settle and measure counts
// Notes:   a wire monitor checks each header byte
`timescale 1ns/1ps
`include "hum_cfg.svh"
module humidity_sensor_bus_timing_reset_tb;
  localparam int unsigned PU = 2000;
  localparam int unsigned SR = 20;
  localparam int unsigned MH = 3000;
  typedef struct packed {
    logic [1:0]  kind;
    logic        nack;
    logic [31:0] data;
    logic        alert;
  } hum_note_s;
  logic        clk, nrst, req_valid, req_read, req_addr_sel, req_hard_rst;
  logic [15:0] req_cmd, temp_val, hum_val, temp_lim, hum_lim;
  logic        done, nack_err, dev_ready, dev_busy;
  logic [31:0] rd_data;
  hum_note_s   note_q[$];
  logic [7:0]  hdr_q[$];
  logic [7:0]  lsb[6];
  logic [7:0]  hsh;
  int          n_mismatch, samples_checked, cyc, t_rel, hbit;
  hum_bus_if hum_bus_if_i ();
  hum_dev #(.PU_CYC(PU), .SR_CYC(SR), .MEAS_L_CYC(40), .MEAS_M_CYC(60),
    .MEAS_H_CYC(MH)) hum_dev_i (.clk(clk), .nrst(nrst), .bus(hum_bus_if_i),
    .temp_val(temp_val), .hum_val(hum_val), .temp_lim(temp_lim),
    .hum_lim(hum_lim), .ready(dev_ready), .busy(dev_busy));
  hum_host hum_host_i (.clk(clk), .nrst(nrst), .bus(hum_bus_if_i),
    .req_valid(req_valid), .req_read(req_read), .req_cmd(req_cmd),
    .req_addr_sel(req_addr_sel), .req_hard_rst(req_hard_rst), .busy(),
    .done(done), .nack_err(nack_err), .rd_data(rd_data));
  hum_chk #(.MEAS_H_CYC(MH)) hum_chk_i (.clk(clk), .nrst(nrst),
    .scl(hum_bus_if_i.scl), .scl_dev_o(hum_bus_if_i.scl_dev_o),
    .scl_dev_oe(hum_bus_if_i.scl_dev_oe), .sda_dev_o(hum_bus_if_i.sda_dev_o),
    .sda_dev_oe(hum_bus_if_i.sda_dev_oe),
    .scl_host_o(hum_bus_if_i.scl_host_o),
    .scl_host_oe(hum_bus_if_i.scl_host_oe),
    .sda_host_o(hum_bus_if_i.sda_host_o),
    .sda_host_oe(hum_bus_if_i.sda_host_oe),
    .addr_sel(hum_bus_if_i.addr_sel),
    .hard_reset_n(hum_bus_if_i.hard_reset_n), .alert(hum_bus_if_i.alert));
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // ----------------------------------------
  // compare, verdict, requests
  // ----------------------------------------
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task print_verdict;
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task req(input logic rd, input logic [15:0] cmd, input logic sel,
           input logic hr, input logic [1:0] kind, input logic nk);
    hum_note_s n;
    int k;
    n = {kind, nk, temp_val, hum_val,
         (temp_val >= temp_lim) || (hum_val >= hum_lim)};
    note_q.push_back(n);
    if (!hr) hdr_q.push_back({sel ? `HUM_ADDR_HI : `HUM_ADDR_LO, rd});
    req_valid = 1;
    req_read = rd;
    req_cmd = cmd;
    req_addr_sel = sel;
    req_hard_rst = hr;
    @(negedge clk);
    req_valid = 0;
    req_hard_rst = 0;
    k = 0;
    while (done !== 1'b1 && k < 8000) begin
      @(negedge clk);
      k++;
    end
    if (done !== 1'b1) cmp("done", 1, 32'(done));
    @(negedge clk);
  endtask
  task wait_idle(input int lim);
    int k;
    k = 0;
    while (!(dev_ready === 1'b1 && dev_busy === 1'b0) && k < lim) begin
      @(negedge clk);
      k++;
    end
    if (!(dev_ready === 1'b1 && dev_busy === 1'b0)) begin
      cmp("idle", 1, 32'(dev_ready && !dev_busy));
    end
  endtask
  // ----------------------------------------
  // result and wire monitors
  // ----------------------------------------
  always @(negedge clk) if (done === 1'b1) begin : mon
    hum_note_s n;
    n = note_q.pop_front();
    if (n.kind != 0) cmp("nack_err", 32'(n.nack), 32'(nack_err));
    if (n.kind == 2) begin
      cmp("rd_data", n.data, rd_data);
      cmp("alert", 32'(n.alert), 32'(hum_bus_if_i.alert));
    end
  end
  always @(negedge hum_bus_if_i.sda) if (hum_bus_if_i.scl === 1'b1) hbit = 0;
  always @(posedge hum_bus_if_i.scl) begin
    hsh = {hsh[6:0], hum_bus_if_i.sda};
    hbit++;
    if (hbit == 8) begin
      cmp("header", 32'(hdr_q.pop_front()), 32'(hsh));
    end
  end
  initial begin
    #2_000_000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    clk = 0; nrst = 0; req_valid = 0; req_read = 0; req_cmd = 0;
    req_addr_sel = 0; req_hard_rst = 0; temp_val = 0; hum_val = 0;
    temp_lim = 0; hum_lim = 0; cyc = 0; hbit = 9;
    lsb = '{`HUM_LSB_STR_H, `HUM_LSB_STR_M, `HUM_LSB_STR_L,
            `HUM_LSB_NOSTR_H, `HUM_LSB_NOSTR_M, `HUM_LSB_NOSTR_L};
    void'($urandom(32'hb3ebd454));
    repeat (12) @(negedge clk);
    nrst = 1;
    t_rel = cyc;
    req(0, {`HUM_CMD_STR, `HUM_LSB_STR_H}, 0, 0, 1, 1);
    wait_idle(PU + 10);
    cmp("ready_time", 1, 32'((cyc - t_rel) <= PU + 4));
    for (int i = 0; i < 6; i++) begin
      temp_val = $urandom;
      hum_val = $urandom;
      temp_lim = $urandom;
      hum_lim = $urandom;
      req(0, {i < 3 ? `HUM_CMD_STR : `HUM_CMD_NOSTR, lsb[i]},
          i[0], 0, 1, 0);
      if (i >= 3) wait_idle(MH + 10);
      req(1, 16'h0, i[0], 0, 2, 0);
    end
    req(0, {`HUM_CMD_NOSTR, `HUM_LSB_NOSTR_H}, 0, 0, 1, 0);
    req(0, {`HUM_CMD_STR, `HUM_LSB_STR_L}, 0, 0, 1, 1);
    req(1, 16'h0, 0, 0, 1, 1);
    wait_idle(MH + 10);
    req(1, 16'h0, 0, 0, 2, 0);
    req(0, `HUM_CMD_SRST, 1, 0, 1, 0);
    wait_idle(SR + 10);
    cmp("ready_soft", 1, 32'(dev_ready));
    cmp("alert_soft", 0, 32'(hum_bus_if_i.alert));
    req(1, 16'h0, 1, 0, 1, 1);
    req(0, 16'h0, 0, 1, 0, 0);
    req(0, {`HUM_CMD_STR, `HUM_LSB_STR_M}, 0, 0, 1, 1);
    wait_idle(PU + 10);
    cmp("ready_hard", 1, 32'(dev_ready));
    print_verdict;
  end
endmodule
